// ==== core/ctac_defines.svh ====
/*
 Register offsets, field positions and reset values of the threshold compare block.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CTAC_DEFINES_SVH
`define CTAC_DEFINES_SVH

// Register offsets on the register port
`define CTAC_ADDR_UV_CLEAR    8'h1B
`define CTAC_ADDR_SPREAD      8'h1C
`define CTAC_ADDR_HOT         8'h1E

// Limit and result field layout
`define CTAC_VAL_MSB          15
`define CTAC_VAL_LSB          4
`define CTAC_VAL_W            12
`define CTAC_LIMIT_MASK       16'hFFF0
`define CTAC_CELL_EN_BIT      0

// Special values
`define CTAC_SPREAD_DISABLE   16'hFFF0
`define CTAC_READ_ZERO        16'h0000

// Reset values
`define CTAC_RST_UV_CLEAR     16'h0000
`define CTAC_RST_SPREAD       16'hFFF0
`define CTAC_RST_HOT          16'h0000

// Cell count limits
`define CTAC_CELLS_DEFAULT    12
`define CTAC_CELLS_MIN        2
`define CTAC_CELLS_MAX        12

`endif

// ==== core/ctac_pkg.sv ====
/*
 Types of the threshold compare block: register request carrier and scan states.
 Assumes ctac_defines.svh is on the include path.
*/
`include "ctac_defines.svh"

package ctac_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} ctac_reg_req_t;

	typedef enum logic [1:0] {
		CTAC_ST_IDLE   = 2'h0,
		CTAC_ST_EVAL   = 2'h1,
		CTAC_ST_COMMIT = 2'h3
	} ctac_state_t;

endpackage

// ==== core/ctac_spread.sv ====
/*
 Highest and lowest cell reading of one scan snapshot, registered one cycle after start.
 Assumes the snapshot is stable while start is high.
*/
`timescale 1ns/1ps
`include "ctac_defines.svh"

module ctac_spread import ctac_pkg::*; #(
	parameter int NUM_CELLS = `CTAC_CELLS_DEFAULT
) (
	// Clock and reset
	input  wire logic                                 core_clk,
	input  wire logic                                 rstn,
	// Snapshot
	input  wire logic                                 start,
	input  wire logic [NUM_CELLS-1:0][`CTAC_VAL_W-1:0] cells,
	// Result
	output logic      [`CTAC_VAL_W-1:0]               highest_cell_reading,
	output logic      [`CTAC_VAL_W-1:0]               lowest_cell_reading,
	output logic                                      valid
);

	logic [`CTAC_VAL_W-1:0] high_next;
	logic [`CTAC_VAL_W-1:0] low_next;

	// Unsigned search over all cells
	always_comb begin
		high_next = cells[0];
		low_next  = cells[0];
		for (int i = 1; i < NUM_CELLS; i++) begin
			if (cells[i] > high_next) begin
				high_next = cells[i];
			end
			if (cells[i] < low_next) begin
				low_next = cells[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			highest_cell_reading <= '0;
			lowest_cell_reading  <= '0;
		end else if (start) begin
			highest_cell_reading <= high_next;
			lowest_cell_reading  <= low_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			valid <= 1'b0;
		end else begin
			valid <= start;
		end
	end

	order_ok_a: assert property (@(posedge core_clk) disable iff (!rstn)
		valid |-> highest_cell_reading >= lowest_cell_reading)
		else $error("highest reading below lowest reading");

endmodule

// ==== core/ctac_top.sv ====
/*
 Threshold compare block: limit registers, scan snapshot, undervoltage, spread and hot alerts.
 Assumes a same-clock register port from the serial engine and a one-cycle scan_done pulse
 with cell and auxiliary results stable in that cycle.
*/
`timescale 1ns/1ps
`include "ctac_defines.svh"

module ctac_top import ctac_pkg::*; #(
	parameter int NUM_CELLS = `CTAC_CELLS_DEFAULT
) (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rstn,
	// Register port
	input  wire ctac_reg_req_t                reg_req,
	output logic      [15:0]                  reg_rdata,
	// Scan results
	input  wire logic                         scan_done,
	input  wire logic [NUM_CELLS-1:0][15:0]   cell_data,
	input  wire logic [15:0]                  undervoltage_set_limit,
	input  wire logic [15:0]                  aux_result_zero,
	input  wire logic [15:0]                  aux_result_first,
	// Alert flags
	output logic      [NUM_CELLS-1:0]         cell_low_alert_flag,
	output logic                              spread_alert_flag,
	output logic                              hot_alert_flag
);

	generate
		if (NUM_CELLS < `CTAC_CELLS_MIN || NUM_CELLS > `CTAC_CELLS_MAX) begin : g_bad
			$error("NUM_CELLS out of range");
		end
	endgenerate

	ctac_state_t                            state_reg;
	logic [15:0]                            undervoltage_clear_limit_reg;
	logic [15:0]                            cell_spread_limit_reg;
	logic [15:0]                            aux_hot_limit_reg;
	logic [NUM_CELLS-1:0][`CTAC_VAL_W-1:0]  snap_cell_reg;
	logic [NUM_CELLS-1:0]                   cell_low_alert_enable;
	logic [`CTAC_VAL_W-1:0]                 snap_set_reg;
	logic [`CTAC_VAL_W-1:0]                 aux_zero_reg;
	logic [`CTAC_VAL_W-1:0]                 aux_first_reg;
	logic [`CTAC_VAL_W-1:0]                 highest_cell_reading;
	logic [`CTAC_VAL_W-1:0]                 lowest_cell_reading;
	logic [`CTAC_VAL_W-1:0]                 spread;
	logic [`CTAC_VAL_W-1:0]                 clear_lim;
	logic [`CTAC_VAL_W-1:0]                 spread_lim;
	logic [`CTAC_VAL_W-1:0]                 hot_lim;
	logic                                   spread_valid;
	logic                                   wr_clear;
	logic                                   wr_spread;
	logic                                   wr_hot;
	logic                                   spread_off_wr;
	logic                                   take_scan;
	logic                                   commit;

	// Decode
	assign wr_clear      = reg_req.wr && (reg_req.addr == `CTAC_ADDR_UV_CLEAR);
	assign wr_spread     = reg_req.wr && (reg_req.addr == `CTAC_ADDR_SPREAD);
	assign wr_hot        = reg_req.wr && (reg_req.addr == `CTAC_ADDR_HOT);
	assign spread_off_wr = wr_spread && ((reg_req.wdata & `CTAC_LIMIT_MASK) == `CTAC_SPREAD_DISABLE);
	assign take_scan     = scan_done && (state_reg == CTAC_ST_IDLE);
	assign commit        = (state_reg == CTAC_ST_COMMIT);

	// Upper 12 bits of each limit
	assign clear_lim  = undervoltage_clear_limit_reg[`CTAC_VAL_MSB:`CTAC_VAL_LSB];
	assign spread_lim = cell_spread_limit_reg[`CTAC_VAL_MSB:`CTAC_VAL_LSB];
	assign hot_lim    = aux_hot_limit_reg[`CTAC_VAL_MSB:`CTAC_VAL_LSB];
	assign spread     = highest_cell_reading - lowest_cell_reading;

	// Limit registers
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			undervoltage_clear_limit_reg <= `CTAC_RST_UV_CLEAR;
		end else if (wr_clear) begin
			undervoltage_clear_limit_reg <= reg_req.wdata & `CTAC_LIMIT_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cell_spread_limit_reg <= `CTAC_RST_SPREAD;
		end else if (wr_spread) begin
			cell_spread_limit_reg <= reg_req.wdata & `CTAC_LIMIT_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			aux_hot_limit_reg <= `CTAC_RST_HOT;
		end else if (wr_hot) begin
			aux_hot_limit_reg <= reg_req.wdata & `CTAC_LIMIT_MASK;
		end
	end

	// Read data
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			reg_rdata <= `CTAC_READ_ZERO;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				`CTAC_ADDR_UV_CLEAR: reg_rdata <= undervoltage_clear_limit_reg;
				`CTAC_ADDR_SPREAD:   reg_rdata <= cell_spread_limit_reg;
				`CTAC_ADDR_HOT:      reg_rdata <= aux_hot_limit_reg;
				default:             reg_rdata <= `CTAC_READ_ZERO;
			endcase
		end
	end

	// Scan sequencing
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= CTAC_ST_IDLE;
		end else begin
			case (state_reg)
				CTAC_ST_IDLE: begin
					if (scan_done) begin
						state_reg <= CTAC_ST_EVAL;
					end
				end
				CTAC_ST_EVAL:   state_reg <= CTAC_ST_COMMIT;
				CTAC_ST_COMMIT: state_reg <= CTAC_ST_IDLE;
				default:        state_reg <= CTAC_ST_IDLE;
			endcase
		end
	end

	// Scan snapshot
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			snap_cell_reg         <= '0;
			cell_low_alert_enable <= '0;
			snap_set_reg          <= '0;
			aux_zero_reg          <= '0;
			aux_first_reg         <= '0;
		end else if (take_scan) begin
			for (int i = 0; i < NUM_CELLS; i++) begin
				snap_cell_reg[i]         <= cell_data[i][`CTAC_VAL_MSB:`CTAC_VAL_LSB];
				cell_low_alert_enable[i] <= cell_data[i][`CTAC_CELL_EN_BIT];
			end
			snap_set_reg  <= undervoltage_set_limit[`CTAC_VAL_MSB:`CTAC_VAL_LSB];
			aux_zero_reg  <= aux_result_zero[`CTAC_VAL_MSB:`CTAC_VAL_LSB];
			aux_first_reg <= aux_result_first[`CTAC_VAL_MSB:`CTAC_VAL_LSB];
		end
	end

	ctac_spread #(
		.NUM_CELLS (NUM_CELLS)
	) u_spread (
		.core_clk             (core_clk),
		.rstn                 (rstn),
		.start                (state_reg == CTAC_ST_EVAL),
		.cells                (snap_cell_reg),
		.highest_cell_reading (highest_cell_reading),
		.lowest_cell_reading  (lowest_cell_reading),
		.valid                (spread_valid)
	);

	// Spread alert
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			spread_alert_flag <= 1'b0;
		end else if (spread_off_wr) begin
			spread_alert_flag <= 1'b0;
		end else if (commit) begin
			spread_alert_flag <= (spread > spread_lim);
		end
	end

	// Hot alert
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hot_alert_flag <= 1'b0;
		end else if (commit) begin
			hot_alert_flag <= (aux_zero_reg < hot_lim) || (aux_first_reg < hot_lim);
		end
	end

	// Per-cell low alerts with hysteresis
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					cell_low_alert_flag[gi] <= 1'b0;
				end else if (commit) begin
					if (!cell_low_alert_enable[gi]) begin
						cell_low_alert_flag[gi] <= 1'b0;
					end else if (snap_cell_reg[gi] < snap_set_reg) begin
						cell_low_alert_flag[gi] <= 1'b1;
					end else if (snap_cell_reg[gi] > clear_lim) begin
						cell_low_alert_flag[gi] <= 1'b0;
					end
				end
			end

			low_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
				commit && cell_low_alert_enable[gi] && (snap_cell_reg[gi] < snap_set_reg)
				|=> cell_low_alert_flag[gi])
				else $error("low alert not raised below set limit");

			low_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
				commit && cell_low_alert_enable[gi] && cell_low_alert_flag[gi]
				&& (snap_cell_reg[gi] <= clear_lim) |=> cell_low_alert_flag[gi])
				else $error("low alert dropped before clear limit");

			low_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
				commit && !cell_low_alert_enable[gi] |=> !cell_low_alert_flag[gi])
				else $error("low alert set while disabled");
		end
	endgenerate

	sequence scan_walk_s;
		(state_reg == CTAC_ST_EVAL) ##1 (state_reg == CTAC_ST_COMMIT) ##1 (state_reg == CTAC_ST_IDLE);
	endsequence

	scan_walk_a: assert property (@(posedge core_clk) disable iff (!rstn)
		take_scan |=> scan_walk_s)
		else $error("scan sequence broken");

	low_stable_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!commit |=> $stable(cell_low_alert_flag))
		else $error("low alerts changed outside a scan");

	limit_nibble_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_req.rd |=> (reg_rdata[3:0] == 4'h0) && (aux_hot_limit_reg[3:0] == 4'h0))
		else $error("low nibble not zero");

	spread_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
		spread_off_wr |=> !spread_alert_flag)
		else $error("spread alert not cleared by disable value");

	spread_wait_a: assert property (@(posedge core_clk) disable iff (!rstn)
		wr_spread && !spread_off_wr && !commit |=> $stable(spread_alert_flag))
		else $error("spread alert changed without scan");

	spread_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
		commit && !spread_off_wr && (spread > spread_lim) |=> spread_alert_flag)
		else $error("spread alert missed");

	hot_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
		commit && ((aux_zero_reg < hot_lim) || (aux_first_reg < hot_lim)) |=> hot_alert_flag)
		else $error("hot alert missed");

	clear_store_a: assert property (@(posedge core_clk) disable iff (!rstn)
		wr_clear |=> undervoltage_clear_limit_reg == ($past(reg_req.wdata) & 16'hFFF0))
		else $error("clear limit not stored");

	spread_ready_a: assert property (@(posedge core_clk) disable iff (!rstn)
		commit |-> spread_valid)
		else $error("spread result not ready at commit");

endmodule

// ==== testbench/ctac_host_model.sv ====
/*
 Host model: register writes and reads on the register port of the threshold compare block.
 Assumes same-clock requests launched after a rising edge, one cycle each, read data one cycle later.
*/
`timescale 1ns/1ps

module ctac_host_model import ctac_pkg::*; (
	// Clock
	input  wire logic        core_clk,
	// Register port
	output ctac_reg_req_t    reg_req,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_req = '0;
	end

	// Idle address and data flip so a stale request value is never seen
	task automatic release_req();
		reg_req.wr    <= 1'b0;
		reg_req.rd    <= 1'b0;
		reg_req.addr  <= ~reg_req.addr;
		reg_req.wdata <= ~reg_req.wdata;
	endtask

	task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
		@(posedge core_clk);
		reg_req.wr    <= 1'b1;
		reg_req.rd    <= 1'b0;
		reg_req.addr  <= addr;
		reg_req.wdata <= data;
		@(posedge core_clk);
		release_req();
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
		@(posedge core_clk);
		reg_req.wr   <= 1'b0;
		reg_req.rd   <= 1'b1;
		reg_req.addr <= addr;
		@(posedge core_clk);
		release_req();
		#1;
		data = reg_rdata;
	endtask
endmodule

// ==== testbench/testbench.sv ====
/*
 Self-checking bench of the threshold compare block: registers, low, spread and hot alerts.
 Assumes the host model drives the register port and the bench drives the scan inputs.
*/
`timescale 1ns/1ps

module testbench import ctac_pkg::*;;
	localparam int NUM_CELLS = 4;
	logic                       core_clk               = 1'b0;
	logic                       rstn                   = 1'b0;
	ctac_reg_req_t              reg_req;
	logic [15:0]                reg_rdata;
	logic                       scan_done              = 1'b0;
	logic [NUM_CELLS-1:0][15:0] cell_data              = {NUM_CELLS{16'h6001}};
	logic [15:0]                undervoltage_set_limit = 16'h4000;
	logic [15:0]                aux_result_zero        = 16'hC000;
	logic [15:0]                aux_result_first       = 16'hC000;
	logic [NUM_CELLS-1:0]       cell_low_alert_flag;
	logic                       spread_alert_flag;
	logic                       hot_alert_flag;
	int                         errors                 = 0;
	int                         num_checks             = 0;
	int                         cycles                 = 0;

	ctac_top #(.NUM_CELLS(NUM_CELLS)) u_ctac_top (
		.core_clk(core_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.scan_done(scan_done), .cell_data(cell_data), .undervoltage_set_limit(undervoltage_set_limit),
		.aux_result_zero(aux_result_zero), .aux_result_first(aux_result_first),
		.cell_low_alert_flag(cell_low_alert_flag), .spread_alert_flag(spread_alert_flag),
		.hot_alert_flag(hot_alert_flag)
	);

	ctac_host_model u_ctac_host_model (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

	always #10 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Flag vector: low flags of cells 3..0, spread, hot
	task automatic check_flags(input string name, input logic [5:0] exp);
		num_checks++;
		if ({cell_low_alert_flag, spread_alert_flag, hot_alert_flag} !== exp) begin
			errors++;
			$display("Error %s expected %b seen %b", name, exp,
				{cell_low_alert_flag, spread_alert_flag, hot_alert_flag});
		end
	endtask

	task automatic read_check(input logic [7:0] addr, input logic [15:0] exp);
		logic [15:0] val;
		u_ctac_host_model.read_reg(addr, val);
		check_reg($sformatf("reg %h", addr), exp, val);
	endtask

	// Cells 2 and 3 keep reading 0x600 with their low alert enabled
	task automatic run_scan(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] a0,
		input logic [15:0] a1);
		@(posedge core_clk);
		scan_done        <= 1'b1;
		cell_data[0]     <= c0;
		cell_data[1]     <= c1;
		aux_result_zero  <= a0;
		aux_result_first <= a1;
		@(posedge core_clk);
		scan_done <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic test_reset();
		check_flags("reset flags", 6'b000000);
		read_check(8'h1B, 16'h0000);
		read_check(8'h1C, 16'hFFF0);
		read_check(8'h1E, 16'h0000);
		read_check(8'h1D, 16'h0000);
	endtask

	task automatic test_regs();
		u_ctac_host_model.write_reg(8'h1B, 16'h1235);
		read_check(8'h1B, 16'h1230);
		u_ctac_host_model.write_reg(8'h1E, 16'hABCF);
		read_check(8'h1E, 16'hABC0);
		u_ctac_host_model.write_reg(8'h1D, 16'h5555);
		read_check(8'h1D, 16'h0000);
	endtask

	task automatic test_low();
		u_ctac_host_model.write_reg(8'h1B, 16'h5000);
		run_scan(16'h3001, 16'h6001, 16'hC000, 16'hC000);
		check_flags("low set", 6'b000100);
		run_scan(16'h4801, 16'h6001, 16'hC000, 16'hC000);
		check_flags("low hold", 6'b000100);
		run_scan(16'h500F, 16'h6001, 16'hC000, 16'hC000);
		check_flags("low equal clear", 6'b000100);
		run_scan(16'h5011, 16'h6001, 16'hC000, 16'hC000);
		check_flags("low cleared", 6'b000000);
		run_scan(16'h3000, 16'h3FF1, 16'hC000, 16'hC000);
		check_flags("low enable", 6'b001000);
		@(posedge core_clk);
		undervoltage_set_limit <= 16'h3000;
		run_scan(16'h3001, 16'h3FF1, 16'hC000, 16'hC000);
		check_flags("low new set", 6'b001000);
	endtask

	task automatic test_spread();
		run_scan(16'hF001, 16'h6001, 16'hC000, 16'hC000);
		check_flags("spread disabled", 6'b000000);
		u_ctac_host_model.write_reg(8'h1C, 16'h1000);
		run_scan(16'h7011, 16'h6001, 16'hC000, 16'hC000);
		check_flags("spread over", 6'b000010);
		run_scan(16'h7001, 16'h6001, 16'hC000, 16'hC000);
		check_flags("spread equal", 6'b000000);
		run_scan(16'h7011, 16'h6001, 16'hC000, 16'hC000);
		u_ctac_host_model.write_reg(8'h1C, 16'h2000);
		@(posedge core_clk);
		#1;
		check_flags("spread kept", 6'b000010);
		run_scan(16'h7011, 16'h6001, 16'hC000, 16'hC000);
		check_flags("spread rescan", 6'b000000);
		u_ctac_host_model.write_reg(8'h1C, 16'h1000);
		run_scan(16'h7011, 16'h6001, 16'hC000, 16'hC000);
		u_ctac_host_model.write_reg(8'h1C, 16'hFFF5);
		#1;
		check_flags("spread off", 6'b000000);
		read_check(8'h1C, 16'hFFF0);
	endtask

	task automatic test_hot();
		logic [15:0] a0 [4] = '{16'h7FF0, 16'hC000, 16'h800F, 16'hF000};
		logic [15:0] a1 [4] = '{16'hC000, 16'h7FFF, 16'h8000, 16'hFFF0};
		logic        hot [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
		u_ctac_host_model.write_reg(8'h1E, 16'h8000);
		for (int i = 0; i < 4; i++) begin
			run_scan(16'h6001, 16'h6001, a0[i], a1[i]);
			check_flags("hot", {5'b00000, hot[i]});
		end
	endtask

	// Reset in mid-run returns flags and limits to their reset values
	task automatic test_mid_reset();
		run_scan(16'h6001, 16'h6001, 16'h7000, 16'hC000);
		check_flags("hot before reset", 6'b000001);
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		#1;
		check_flags("flags after reset", 6'b000000);
		read_check(8'h1E, 16'h0000);
		read_check(8'h1C, 16'hFFF0);
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		#1;
		test_reset();
		test_regs();
		test_low();
		test_spread();
		test_hot();
		test_mid_reset();
		complete_run();
	end
endmodule
